// [hw/orient_regs.sv]
`timescale 1ns/100ps
`include "orient_defs.svh"

// Behaviour
// - Read-only eight-bit identification code register
// - Full-scale field selects 2g, 4g, 8g
// - Output select bit picks high-pass samples
// - Cut-off select indexed by rate, oversampling
// - Tap high-pass bypass bit, resets clear
// - Tap low-pass enable bit, resets clear
// - Orientation field encodes four positions
// - Back/front bit: zero front, one back
// - Lockout bit set past Z-tilt angle
// - Change flag on first detection, changes
// - Status read clears flag and interrupt
// - Status fields keep tracking while flagged
// - Over 1.25g on any axis holds orientation
// - Status fields read zero after power-up
// - Config: debounce mode bit7, enable bit6
// - Data config: output select bit4, scale
// - Debounce lapse: mode0 decrement, mode1 clear
// - Detection runs only while enabled
// - Wake/sleep change resets debounce counter
// - Interrupt source follows flag, read clears
module orient_regs #(
   // Arbitrary neutral identification value
   parameter logic [7:0] IDENTITY = 8'h5c,
   parameter logic [11:0] ZLOCK_LIMIT = 12'h380
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   input wire logic sample_valid_i,
   input wire orient_pkg::accel_sample_t sample_i,
   input wire orient_pkg::system_mode_t system_mode_i,
   input wire logic [2:0] output_data_rate_i,
   input wire orient_pkg::oversampling_t oversampling_i,
   input wire logic [7:0] debounce_count_i,
   input wire logic orient_irq_enable_i,
   output orient_pkg::filter_ctrl_t filter_ctrl_o,
   output orient_pkg::orient_view_t orient_view_o,
   output logic orientation_changed_o,
   output logic orientation_irq_source_o
);
   import orient_pkg::*;

   // ========================================
   // Elaboration checks
   if (ZLOCK_LIMIT == 12'h000 || ZLOCK_LIMIT[11]) begin : g_bad_zlock
      $error("ZLOCK_LIMIT must lie in 1..2047");
   end

   // ========================================
   // Configuration state
   logic [1:0] full_scale_select_r, full_scale_select_nxt;
   logic highpass_output_select_r, highpass_output_select_nxt;
   logic tap_highpass_bypass_r, tap_highpass_bypass_nxt;
   logic tap_lowpass_enable_r, tap_lowpass_enable_nxt;
   logic [1:0] cutoff_select_r, cutoff_select_nxt;
   logic debounce_mode_r, debounce_mode_nxt;
   logic orientation_enable_r, orientation_enable_nxt;
   logic [3:0] cutoff_shift;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
      hit = (a == t);
   endfunction : hit

   always_comb begin
      full_scale_select_nxt = full_scale_select_r;
      highpass_output_select_nxt = highpass_output_select_r;
      tap_highpass_bypass_nxt = tap_highpass_bypass_r;
      tap_lowpass_enable_nxt = tap_lowpass_enable_r;
      cutoff_select_nxt = cutoff_select_r;
      debounce_mode_nxt = debounce_mode_r;
      orientation_enable_nxt = orientation_enable_r;
      if (reg_wr_i) begin
         if (hit(reg_addr_i, `ADDR_RANGE_FILTER_CONFIG)) begin
            // Reserved code 3 is stored as written
            full_scale_select_nxt =
               reg_wdata_i[`CFG_FS_MSB:`CFG_FS_LSB];
            highpass_output_select_nxt =
               reg_wdata_i[`CFG_HPO_BIT];
         end
         if (hit(reg_addr_i, `ADDR_HIGHPASS_CUTOFF_SELECT)) begin
            tap_highpass_bypass_nxt = reg_wdata_i[`CUT_BYP_BIT];
            tap_lowpass_enable_nxt = reg_wdata_i[`CUT_LPF_BIT];
            cutoff_select_nxt =
               reg_wdata_i[`CUT_SEL_MSB:`CUT_SEL_LSB];
         end
         if (hit(reg_addr_i, `ADDR_ORIENTATION_CONFIG)) begin
            debounce_mode_nxt = reg_wdata_i[`PCFG_DBM_BIT];
            orientation_enable_nxt = reg_wdata_i[`PCFG_EN_BIT];
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         full_scale_select_r <= `FS_RESET;
         highpass_output_select_r <= `HPO_RESET;
         tap_highpass_bypass_r <= `BYP_RESET;
         tap_lowpass_enable_r <= `LPF_RESET;
         cutoff_select_r <= `SEL_RESET;
         debounce_mode_r <= `DBM_RESET;
         orientation_enable_r <= `EN_RESET;
      end else begin
         full_scale_select_r <= full_scale_select_nxt;
         highpass_output_select_r <= highpass_output_select_nxt;
         tap_highpass_bypass_r <= tap_highpass_bypass_nxt;
         tap_lowpass_enable_r <= tap_lowpass_enable_nxt;
         cutoff_select_r <= cutoff_select_nxt;
         debounce_mode_r <= debounce_mode_nxt;
         orientation_enable_r <= orientation_enable_nxt;
      end
   end

   hpf_cutoff_lut u_cutoff (
      .cutoff_select_i(cutoff_select_r),
      .output_data_rate_i(output_data_rate_i),
      .oversampling_i(oversampling_i),
      .cutoff_shift_o(cutoff_shift)
   );

   // Data path follows the stored fields directly
   always_comb begin
      filter_ctrl_o.full_scale_select = full_scale_select_r;
      filter_ctrl_o.highpass_output_select = highpass_output_select_r;
      filter_ctrl_o.tap_highpass_bypass = tap_highpass_bypass_r;
      filter_ctrl_o.tap_lowpass_enable = tap_lowpass_enable_r;
      filter_ctrl_o.cutoff_shift = cutoff_shift;
   end

   // ========================================
   // Orientation detection
   orient_view_t view;
   logic change_evt;

   orient_detect #(
      .ZLOCK_LIMIT(ZLOCK_LIMIT)
   ) u_detect (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .enable_i(orientation_enable_r),
      .debounce_mode_i(debounce_mode_r),
      .debounce_count_i(debounce_count_i),
      .system_mode_i(system_mode_i),
      .full_scale_select_i(full_scale_select_r),
      .sample_valid_i(sample_valid_i),
      .sample_i(sample_i),
      .view_o(view),
      .change_o(change_evt)
   );

   // ========================================
   // Change flag, interrupt source and read data
   logic changed_r, changed_nxt;
   logic irq_src_r, irq_src_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic status_rd;

   assign status_rd = reg_rd_i && hit(reg_addr_i, `ADDR_ORIENTATION_STATUS);

   always_comb begin
      changed_nxt = changed_r;
      irq_src_nxt = irq_src_r;
      // Clear first so a coincident event still lands
      if (status_rd) begin
         changed_nxt = 1'b0;
         irq_src_nxt = 1'b0;
      end
      if (change_evt) begin
         changed_nxt = 1'b1;
         if (orient_irq_enable_i) begin
            irq_src_nxt = 1'b1;
         end
      end
   end

   always_comb begin
      rdata_nxt = rdata_r;
      if (reg_rd_i) begin
         rdata_nxt = `BYTE_ZERO;
         unique case (reg_addr_i)
            `ADDR_DEVICE_IDENTITY: rdata_nxt = IDENTITY;
            `ADDR_RANGE_FILTER_CONFIG: begin
               rdata_nxt[`CFG_HPO_BIT] = highpass_output_select_r;
               rdata_nxt[`CFG_FS_MSB:`CFG_FS_LSB] =
                  full_scale_select_r;
            end
            `ADDR_HIGHPASS_CUTOFF_SELECT: begin
               rdata_nxt[`CUT_BYP_BIT] = tap_highpass_bypass_r;
               rdata_nxt[`CUT_LPF_BIT] = tap_lowpass_enable_r;
               rdata_nxt[`CUT_SEL_MSB:`CUT_SEL_LSB] = cutoff_select_r;
            end
            `ADDR_ORIENTATION_STATUS: begin
               // Fields are live, never frozen by the flag
               rdata_nxt[`STAT_CHG_BIT] = changed_r;
               rdata_nxt[`STAT_LOCK_BIT] = view.tilt_lockout;
               rdata_nxt[`STAT_ORIENT_MSB:`STAT_ORIENT_LSB] =
                  view.orientation_state;
               rdata_nxt[`STAT_BACK_BIT] =
                  view.back_front_state;
            end
            `ADDR_ORIENTATION_CONFIG: begin
               rdata_nxt[`PCFG_DBM_BIT] = debounce_mode_r;
               rdata_nxt[`PCFG_EN_BIT] = orientation_enable_r;
            end
            default: rdata_nxt = `BYTE_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         changed_r <= 1'b0;
         irq_src_r <= 1'b0;
         rdata_r <= `BYTE_ZERO;
      end else begin
         changed_r <= changed_nxt;
         irq_src_r <= irq_src_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata_o = rdata_r;
   assign orient_view_o = view;
   assign orientation_changed_o = changed_r;
   assign orientation_irq_source_o = irq_src_r;

   // ========================================
   // Checks
   property p_identity_read;
      @(posedge clk_i) disable iff (!resetn_i)
      (reg_rd_i && hit(reg_addr_i, `ADDR_DEVICE_IDENTITY))
         |=> (reg_rdata_o == IDENTITY);
   endproperty
   a_identity_read: assert property (p_identity_read)
      else $error("identity read returned wrong code");

   property p_scale_write;
      @(posedge clk_i) disable iff (!resetn_i)
      (reg_wr_i && hit(reg_addr_i, `ADDR_RANGE_FILTER_CONFIG))
         |=> (filter_ctrl_o.full_scale_select ==
              $past(reg_wdata_i[`CFG_FS_MSB:`CFG_FS_LSB]));
   endproperty
   a_scale_write: assert property (p_scale_write)
      else $error("full-scale field did not take the write");

   property p_hpo_write;
      @(posedge clk_i) disable iff (!resetn_i)
      (reg_wr_i && hit(reg_addr_i, `ADDR_RANGE_FILTER_CONFIG))
         |=> (filter_ctrl_o.highpass_output_select ==
              $past(reg_wdata_i[`CFG_HPO_BIT]));
   endproperty
   a_hpo_write: assert property (p_hpo_write)
      else $error("output select did not take the write");

   property p_tap_write;
      @(posedge clk_i) disable iff (!resetn_i)
      (reg_wr_i && hit(reg_addr_i, `ADDR_HIGHPASS_CUTOFF_SELECT))
         |=> (filter_ctrl_o.tap_highpass_bypass ==
              $past(reg_wdata_i[`CUT_BYP_BIT])) &&
             (filter_ctrl_o.tap_lowpass_enable ==
              $past(reg_wdata_i[`CUT_LPF_BIT]));
   endproperty
   a_tap_write: assert property (p_tap_write)
      else $error("tap filter bits did not take the write");

   property p_read_clears;
      @(posedge clk_i) disable iff (!resetn_i)
      (status_rd && !change_evt) |=> !changed_r && !irq_src_r;
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("status read left flag or interrupt set");

   property p_event_sets;
      @(posedge clk_i) disable iff (!resetn_i)
      change_evt |=> changed_r;
   endproperty
   a_event_sets: assert property (p_event_sets)
      else $error("change event lost");

   property p_irq_follows;
      @(posedge clk_i) disable iff (!resetn_i)
      (change_evt && orient_irq_enable_i) |=> irq_src_r && changed_r;
   endproperty
   a_irq_follows: assert property (p_irq_follows)
      else $error("interrupt source missed an enabled change");

   property p_cfg_reserved;
      @(posedge clk_i) disable iff (!resetn_i)
      (reg_rd_i && hit(reg_addr_i, `ADDR_ORIENTATION_CONFIG))
         |=> (reg_rdata_o[5:0] == 6'h00) &&
             (reg_rdata_o[`PCFG_DBM_BIT] == $past(debounce_mode_r));
   endproperty
   a_cfg_reserved: assert property (p_cfg_reserved)
      else $error("orientation config readback wrong");

   property p_data_cfg_reserved;
      @(posedge clk_i) disable iff (!resetn_i)
      (reg_rd_i && hit(reg_addr_i, `ADDR_RANGE_FILTER_CONFIG))
         |=> (reg_rdata_o[7:5] == 3'h0) && (reg_rdata_o[3:2] == 2'h0);
   endproperty
   a_data_cfg_reserved: assert property (p_data_cfg_reserved)
      else $error("data config reserved bits not zero");

endmodule : orient_regs

// [hw/orient_defs.svh]
`ifndef ORIENT_DEFS_SVH
`define ORIENT_DEFS_SVH

// ========================================
// Register offsets
`define ADDR_DEVICE_IDENTITY 8'h0d
`define ADDR_RANGE_FILTER_CONFIG 8'h0e
`define ADDR_HIGHPASS_CUTOFF_SELECT 8'h0f
`define ADDR_ORIENTATION_STATUS 8'h10
`define ADDR_ORIENTATION_CONFIG 8'h11

// ========================================
// Field positions
`define CFG_HPO_BIT 4
`define CFG_FS_MSB 1
`define CFG_FS_LSB 0
`define CUT_BYP_BIT 5
`define CUT_LPF_BIT 4
`define CUT_SEL_MSB 1
`define CUT_SEL_LSB 0
`define STAT_CHG_BIT 7
`define STAT_LOCK_BIT 6
`define STAT_ORIENT_MSB 2
`define STAT_ORIENT_LSB 1
`define STAT_BACK_BIT 0
`define PCFG_DBM_BIT 7
`define PCFG_EN_BIT 6

// ========================================
// Reset values
`define FS_RESET 2'h0
`define SEL_RESET 2'h0
`define HPO_RESET 1'h0
`define BYP_RESET 1'h0
`define LPF_RESET 1'h0
`define DBM_RESET 1'h1
`define EN_RESET 1'h0
`define BYTE_ZERO 8'h00
`define COUNT_ZERO 8'h00
`define COUNT_ONE 8'h01

// ========================================
// Full-scale codes and 1.25g hold limits in 12-bit counts
`define FS_2G 2'h0
`define FS_4G 2'h1
`define FS_8G 2'h2
`define FS_RESERVED 2'h3
`define HOLD_LIM_2G 12'h500
`define HOLD_LIM_4G 12'h280
`define HOLD_LIM_8G 12'h140

`endif

// [hw/orient_pkg.sv]
package orient_pkg;

   typedef enum logic [1:0] {
      PORTRAIT_UP = 2'b00,
      PORTRAIT_DOWN = 2'b01,
      LANDSCAPE_RIGHT = 2'b10,
      LANDSCAPE_LEFT = 2'b11
   } orientation_t;

   typedef enum logic [1:0] {
      MODE_STANDBY = 2'b00,
      MODE_WAKE = 2'b01,
      MODE_SLEEP = 2'b10,
      MODE_UNUSED = 2'b11
   } system_mode_t;

   typedef enum logic [1:0] {
      OS_NORMAL = 2'b00,
      OS_LOW_NOISE = 2'b01,
      OS_HIGH_RES = 2'b10,
      OS_LOW_POWER = 2'b11
   } oversampling_t;

   typedef struct packed {
      logic signed [11:0] x;
      logic signed [11:0] y;
      logic signed [11:0] z;
   } accel_sample_t;

   typedef struct packed {
      logic tilt_lockout;
      orientation_t orientation_state;
      logic back_front_state;
   } orient_view_t;

   // Cut-off is 16 Hz shifted right by cutoff_shift
   typedef struct packed {
      logic [1:0] full_scale_select;
      logic highpass_output_select;
      logic tap_highpass_bypass;
      logic tap_lowpass_enable;
      logic [3:0] cutoff_shift;
   } filter_ctrl_t;

endpackage : orient_pkg

// [hw/hpf_cutoff_lut.sv]
`timescale 1ns/100ps
`include "orient_defs.svh"

module hpf_cutoff_lut (
   input wire logic [1:0] cutoff_select_i,
   input wire logic [2:0] output_data_rate_i,
   input wire orient_pkg::oversampling_t oversampling_i,
   output logic [3:0] cutoff_shift_o
);
   import orient_pkg::*;

   // Rate code 0 is 800 Hz, 7 is 1.56 Hz; codes 5..7 share a column, 4..7 in normal oversampling
   logic [3:0] base;

   always_comb begin
      base = 4'h0;
      unique case (oversampling_i)
         OS_NORMAL: begin
            unique case (output_data_rate_i)
               3'h0, 3'h1: base = 4'h0;
               3'h2: base = 4'h1;
               3'h3: base = 4'h2;
               default: base = 4'h3;
            endcase
         end
         OS_LOW_NOISE: begin
            unique case (output_data_rate_i)
               3'h0, 3'h1: base = 4'h0;
               3'h2: base = 4'h1;
               3'h3: base = 4'h2;
               3'h4: base = 4'h3;
               default: base = 4'h5;
            endcase
         end
         OS_HIGH_RES: base = 4'h0;
         OS_LOW_POWER: begin
            unique case (output_data_rate_i)
               3'h0: base = 4'h0;
               3'h1: base = 4'h1;
               3'h2: base = 4'h2;
               3'h3: base = 4'h3;
               3'h4: base = 4'h4;
               default: base = 4'h6;
            endcase
         end
      endcase
      cutoff_shift_o = base + {2'h0, cutoff_select_i};
   end

endmodule : hpf_cutoff_lut

// [hw/orient_detect.sv]
`timescale 1ns/100ps
`include "orient_defs.svh"

module orient_detect #(
   parameter logic [11:0] ZLOCK_LIMIT = 12'h380
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic enable_i,
   input wire logic debounce_mode_i,
   input wire logic [7:0] debounce_count_i,
   input wire orient_pkg::system_mode_t system_mode_i,
   input wire logic [1:0] full_scale_select_i,
   input wire logic sample_valid_i,
   input wire orient_pkg::accel_sample_t sample_i,
   output orient_pkg::orient_view_t view_o,
   output logic change_o
);
   import orient_pkg::*;

   typedef enum logic [1:0] {
      DET_IDLE = 2'b00,
      DET_FIRST = 2'b01,
      DET_TRACK = 2'b10
   } det_state_t;

   function automatic logic [11:0] mag(input logic signed [11:0] v);
      mag = v[11] ? 12'(-v) : 12'(v);
   endfunction : mag

   det_state_t state_r, state_nxt;
   orient_view_t view_r, view_nxt, cand;
   logic change_r, change_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   system_mode_t mode_r;
   logic [11:0] hold_lim;
   logic hold, run, sleep_wake;

   always_comb begin
      unique case (full_scale_select_i)
         `FS_2G: hold_lim = `HOLD_LIM_2G;
         `FS_4G: hold_lim = `HOLD_LIM_4G;
         `FS_8G: hold_lim = `HOLD_LIM_8G;
         `FS_RESERVED: hold_lim = `HOLD_LIM_8G;
      endcase
   end

   // Any axis past 1.25g freezes the reported position
   assign hold = (mag(sample_i.x) > hold_lim) ||
                 (mag(sample_i.y) > hold_lim) ||
                 (mag(sample_i.z) > hold_lim);
   assign run = enable_i && (system_mode_i != MODE_STANDBY);
   assign sleep_wake = ((mode_r == MODE_WAKE) &&
                        (system_mode_i == MODE_SLEEP)) ||
                       ((mode_r == MODE_SLEEP) &&
                        (system_mode_i == MODE_WAKE));

   always_comb begin
      cand.tilt_lockout = mag(sample_i.z) > ZLOCK_LIMIT;
      cand.back_front_state = sample_i.z[11];
      if (mag(sample_i.y) >= mag(sample_i.x)) begin
         cand.orientation_state = sample_i.y[11] ? PORTRAIT_DOWN
                                                 : PORTRAIT_UP;
      end else begin
         cand.orientation_state = sample_i.x[11] ? LANDSCAPE_LEFT
                                                 : LANDSCAPE_RIGHT;
      end
   end

   always_comb begin
      state_nxt = state_r;
      view_nxt = view_r;
      cnt_nxt = cnt_r;
      change_nxt = 1'b0;
      unique case (state_r)
         DET_IDLE: begin
            cnt_nxt = `COUNT_ZERO;
            if (run) begin
               state_nxt = DET_FIRST;
            end
         end
         DET_FIRST: begin
            if (!run) begin
               state_nxt = DET_IDLE;
            end else if (sample_valid_i && !hold) begin
               view_nxt = cand;
               change_nxt = 1'b1;
               state_nxt = DET_TRACK;
            end
         end
         DET_TRACK: begin
            if (!run) begin
               state_nxt = DET_IDLE;
            end else if (sample_valid_i && !hold) begin
               if (cand != view_r) begin
                  if (cnt_r >= debounce_count_i) begin
                     view_nxt = cand;
                     change_nxt = 1'b1;
                     cnt_nxt = `COUNT_ZERO;
                  end else begin
                     cnt_nxt = cnt_r + `COUNT_ONE;
                  end
               end else if (debounce_mode_i) begin
                  cnt_nxt = `COUNT_ZERO;
               end else if (cnt_r != `COUNT_ZERO) begin
                  cnt_nxt = cnt_r - `COUNT_ONE;
               end
            end
         end
         default: state_nxt = DET_IDLE;
      endcase
      if (sleep_wake) begin
         cnt_nxt = `COUNT_ZERO;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= DET_IDLE;
         view_r <= '0;
         cnt_r <= `COUNT_ZERO;
         change_r <= 1'b0;
         mode_r <= MODE_STANDBY;
      end else begin
         state_r <= state_nxt;
         view_r <= view_nxt;
         cnt_r <= cnt_nxt;
         change_r <= change_nxt;
         mode_r <= system_mode_i;
      end
   end

   assign view_o = view_r;
   assign change_o = change_r;

   property p_hold_freezes;
      @(posedge clk_i) disable iff (!resetn_i)
      (sample_valid_i && hold) |=> (view_r == $past(view_r));
   endproperty
   a_hold_freezes: assert property (p_hold_freezes)
      else $error("orientation moved during over-range hold");

   property p_sleep_wake_clears;
      @(posedge clk_i) disable iff (!resetn_i)
      sleep_wake |=> (cnt_r == `COUNT_ZERO);
   endproperty
   a_sleep_wake_clears: assert property (p_sleep_wake_clears)
      else $error("debounce count survived a wake/sleep change");

   property p_idle_when_off;
      @(posedge clk_i) disable iff (!resetn_i)
      !run [*2] |-> (state_r == DET_IDLE) && !change_r;
   endproperty
   a_idle_when_off: assert property (p_idle_when_off)
      else $error("detection active while disabled");

endmodule : orient_detect

// [test/host_model.sv]
`timescale 1ns/100ps
// ========================================
// Host side of the register strobe port
module host_model (
   input wire logic clk_i,
   input wire logic [7:0] reg_rdata_i,
   output logic [7:0] reg_addr_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_wdata_o
);
   initial begin
      reg_addr_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_wdata_o = 8'h00;
   end
   // Identity stays read-only, reserved scale never sent
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      if (a == 8'h0d || (a == 8'h0e && &d[1:0])) return;
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge clk_i);
      reg_wr_o <= 1'b0;
      reg_wdata_o <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge clk_i);
      reg_rd_o <= 1'b0;
      #1 d = reg_rdata_i;
   endtask : rd
endmodule : host_model

// [test/orient_regs_tb.sv]
`timescale 1ns/100ps
module orient_regs_tb;
   import orient_pkg::*;
   // Arbitrary identity value
   localparam logic [7:0] ID = 8'h3b;
   logic clk_i;
   logic resetn_i = 1'b0;
   logic sample_valid = 1'b0;
   logic irq_en = 1'b0;
   logic [7:0] dbc = 8'h00;
   logic [2:0] output_data_rate = 3'h0;
   accel_sample_t sample = '0;
   system_mode_t mode = MODE_WAKE;
   oversampling_t os = OS_NORMAL;
   logic [7:0] addr, wdata, rdata, got;
   logic reg_wr, reg_rd, changed, irq;
   filter_ctrl_t fc;
   orient_view_t view;
   int error_cnt = 0;
   int comparisons = 0;
   logic [7:0] rst_a [6] = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h20};
   logic [7:0] rst_e [6] = '{ID, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
   // Packed as select, rate, oversampling, expected shift
   logic [10:0] cut [8] = '{11'h000, 11'h201, 11'h402, 11'h603,
                            11'h103, 11'h3d6, 11'h5e2, 11'h7f9};
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   host_model u_host (.clk_i(clk_i), .reg_rdata_i(rdata),
      .reg_addr_o(addr), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
      .reg_wdata_o(wdata));
   orient_regs #(.IDENTITY(ID)) u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
      .reg_addr_i(addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .sample_valid_i(sample_valid), .sample_i(sample),
      .system_mode_i(mode), .output_data_rate_i(output_data_rate),
      .oversampling_i(os), .debounce_count_i(dbc),
      .orient_irq_enable_i(irq_en), .filter_ctrl_o(fc),
      .orient_view_o(view), .orientation_changed_o(changed),
      .orientation_irq_source_o(irq));
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH at %0t: got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      u_host.rd(a, got);
      chk(got, e);
   endtask : rchk
   // Sample line shows a changed pattern once valid drops
   task automatic smp(input logic [35:0] s);
      @(posedge clk_i);
      sample <= s;
      sample_valid <= 1'b1;
      @(posedge clk_i);
      sample_valid <= 1'b0;
      sample <= ~s;
      repeat (3) @(posedge clk_i);
      #1;
   endtask : smp
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish
   // ========================================
   // Test sequence
   initial begin
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      for (int i = 0; i < 6; i++) rchk(rst_a[i], rst_e[i]);
      chk({3'h0, fc[8:4]}, 8'h00);
      chk({2'h0, changed, irq, view}, 8'h00);
      $display("test reset done");
      u_host.wr(8'h10, 8'hff);
      rchk(8'h10, 8'h00);
      for (int f = 0; f < 3; f++) begin
         u_host.wr(8'h0e, {3'h7, f[0], 2'h3, f[1:0]});
         rchk(8'h0e, {3'h0, f[0], 2'h0, f[1:0]});
         chk({5'h0, fc[8:6]}, {5'h0, f[1:0], f[0]});
      end
      u_host.wr(8'h0e, 8'h00);
      $display("test config done");
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i);
         output_data_rate <= cut[i][8:6];
         os <= oversampling_t'(cut[i][5:4]);
         u_host.wr(8'h0f, {4'hf, 2'h0, cut[i][10:9]});
         rchk(8'h0f, {4'h3, 2'h0, cut[i][10:9]});
         chk({4'h0, fc[3:0]}, {4'h0, cut[i][3:0]});
         chk({6'h0, fc[5:4]}, 8'h03);
      end
      $display("test cutoff done");
      u_host.wr(8'h11, 8'hff);
      rchk(8'h11, 8'hc0);
      smp(36'h000190190);
      chk({7'h0, changed}, 8'h01);
      rchk(8'h10, 8'h80);
      rchk(8'h10, 8'h00);
      smp(36'h190000e70);
      chk({4'h0, view}, 8'h05);
      smp(36'h000e70190);
      rchk(8'h10, 8'h82);
      @(posedge clk_i);
      irq_en <= 1'b1;
      smp(36'he700003e8);
      chk({7'h0, irq}, 8'h01);
      rchk(8'h10, 8'hc6);
      chk({7'h0, irq}, 8'h00);
      smp(36'h0007d0000);
      rchk(8'h10, 8'h46);
      u_host.wr(8'h11, 8'h80);
      smp(36'h000190190);
      rchk(8'h10, 8'h46);
      $display("test orientation done");
      // Count of two; the middle match only steps the count back
      @(posedge clk_i);
      dbc <= 8'h02;
      u_host.wr(8'h11, 8'h40);
      smp(36'h000190190);
      rchk(8'h10, 8'h80);
      repeat (2) smp(36'h190000190);
      smp(36'h000190190);
      repeat (2) smp(36'h190000190);
      rchk(8'h10, 8'h84);
      repeat (2) smp(36'h000190190);
      @(posedge clk_i);
      mode <= MODE_SLEEP;
      smp(36'h000190190);
      rchk(8'h10, 8'h04);
      @(posedge clk_i);
      mode <= MODE_STANDBY;
      smp(36'h000190190);
      rchk(8'h10, 8'h04);
      @(posedge clk_i);
      mode <= MODE_WAKE;
      smp(36'h190000190);
      rchk(8'h10, 8'h84);
      $display("test debounce done");
      tally_and_finish();
   end
   // Whole run is about a thousand ns
   initial begin
      #20000;
      error_cnt++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule : orient_regs_tb
